// ### erc_pkg.sv
package erc_pkg;

  // ==========================================================================
  // chip operating modes
  typedef enum logic [2:0] {
    ERC_MODE_INIT      = 3'h0,
    ERC_MODE_NORMAL    = 3'h1,
    ERC_MODE_STOP      = 3'h3,
    ERC_MODE_SLEEP     = 3'h2,
    ERC_MODE_RESTART   = 3'h6,
    ERC_MODE_FAIL_SAFE = 3'h7
  } erc_mode_t;

  // ==========================================================================
  // configuration lock states; unlocked -> stand-alone flips one bit, unlocked -> load share flips two
  typedef enum logic [1:0] {
    ERC_CFG_NONE       = 2'h0,
    ERC_CFG_STANDALONE = 2'h1,
    ERC_CFG_LOADSHARE  = 2'h3
  } erc_cfg_t;

  // ==========================================================================
  // software control write, one-cycle strobes with data
  typedef struct packed {
    logic ctrl_wr;          // mode control register write
    logic ext_reg_enable;
    logic hw_wr;            // hardware_control_reg write
    logic load_share_select;
    logic keep_on_in_supply_undervoltage;
    logic load_share_stop_keep_on;
    logic ext_reg_voltage_select;
    logic oc_clear;         // clear request for overcurrent flag
    logic uv_clear;         // clear request for undervoltage flag
  } erc_sw_t;

  // analog status inputs, asynchronous to core_clk
  typedef struct packed {
    logic supply_uv;        // supply below supply_undervoltage_threshold
    logic shunt_limit;      // shunt voltage threshold reached
    logic out_uv;           // regulator output undervoltage
    logic base_hi;          // base current above rising threshold
    logic base_lo;          // base current below falling threshold
  } erc_ana_t;

  // regulator drive outputs
  typedef struct packed {
    logic reg_on;
    logic hp_stage_on;
    logic lp_stage_on;
    logic current_limit_on;
    logic sel_3v3;
  } erc_drv_t;

  // ==========================================================================
  // reset value and synchroniser stage count
  localparam logic ERC_RST_BIT = 1'b0;
  localparam int   ERC_SYNC_STAGES = 2;

endpackage

// ### erc_sync.sv
`timescale 1ns/10ps
module erc_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import erc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } erc_sync_state_t;

  erc_sync_state_t state_q;
  erc_sync_state_t state_d;

  // ==========================================================================
  // two-flop synchroniser; first stage is read only by the second
  always_comb begin
    state_d.meta   = async_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;

endmodule

// ### erc_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// - enable in Normal selects stand-alone regulator
// - load-share bit selects load-sharing configuration
// - first set locks configuration, later ignored
// - lock survives soft reset, lost at power
// - stand-alone locked by enable with share 0
// - stand-alone change ignored, no SPI failure
// - load sharing locks; enable bit has no effect
// - load-share change attempt sets SPI failure
// - regulator state follows chip mode table
// - load share off in Stop unless keep-on
// - load share stop keep-on keeps regulator active
// - Stop: high-power stage by base current hysteresis
// - Normal: only high-power stage runs
// - supply undervoltage switches off unless keep-on
// - stand-alone overcurrent limits, sets clearable flag
// - stand-alone undervoltage reported by flag
// - load sharing never signals undervoltage
// - load sharing: no limit, no overcurrent flag
// - load sharing shuts down in Fail-Safe
// - voltage select 0=5.0V 1=3.3V stand-alone only
module erc_ctrl (
  // clock and resets
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               por_n,
  // chip mode and software control
  input  wire erc_pkg::erc_mode_t chip_mode,
  input  wire erc_pkg::erc_sw_t   sw,
  // analog status from pins
  input  wire erc_pkg::erc_ana_t  ana,
  // regulator drive
  output erc_pkg::erc_drv_t       drv,
  // status readback
  output erc_pkg::erc_cfg_t       cfg_lock,
  output logic                    ext_reg_enable,
  output logic                    load_share_select,
  output logic                    keep_on_in_supply_undervoltage,
  output logic                    load_share_stop_keep_on,
  output logic                    ext_reg_voltage_select,
  output logic                    ext_reg_overcurrent_flag,
  output logic                    ext_reg_undervoltage_flag,
  output logic                    spi_fail_pulse
);
  import erc_pkg::*;

  // ==========================================================================
  // state
  // lock lives apart: it follows por_n, not the soft reset
  typedef struct packed {
    erc_cfg_t cfg;
  } erc_lock_t;

  typedef struct packed {
    logic     enable;
    logic     share;
    logic     uv_keep;
    logic     stop_keep;
    logic     vsel;
    logic     oc_flag;
    logic     uv_flag;
    logic     fail;
    logic     ls_stop_mem;   // copy of stop_keep, refreshed every cycle
    logic     sa_on;         // stand-alone on/off, frozen outside Normal
    logic     hp_stop;       // stop-mode high-power stage hysteresis
    erc_drv_t drv;
  } erc_state_t;

  erc_lock_t  lock_q;
  erc_lock_t  lock_d;
  erc_state_t state_q;
  erc_state_t state_d;
  erc_ana_t   ana_s;

  // ==========================================================================
  // pin inputs into clock domain
  erc_sync #(
    .WIDTH ($bits(erc_ana_t))
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (ana),
    .sync_out (ana_s)
  );

  // ==========================================================================
  // next state
  logic cfg_attempt;
  logic want_on;
  logic mode_ok;
  logic ls_active;
  logic sa_active;

  always_comb begin
    lock_d      = lock_q;
    state_d     = state_q;
    state_d.fail = 1'b0;
    sa_active   = (lock_q.cfg == ERC_CFG_STANDALONE);
    ls_active   = (lock_q.cfg == ERC_CFG_LOADSHARE);
    cfg_attempt = 1'b0;

    // control bits other than configuration
    if (sw.hw_wr) begin
      state_d.uv_keep   = sw.keep_on_in_supply_undervoltage;
      state_d.stop_keep = sw.load_share_stop_keep_on;
      state_d.vsel      = sw.ext_reg_voltage_select;
    end

    unique case (lock_q.cfg)
      ERC_CFG_NONE: begin
        if (sw.hw_wr && sw.load_share_select) begin
          lock_d.cfg    = ERC_CFG_LOADSHARE;
          state_d.share = 1'b1;
        end else if (sw.ctrl_wr && sw.ext_reg_enable
                     && chip_mode == ERC_MODE_NORMAL) begin
          lock_d.cfg     = ERC_CFG_STANDALONE;
          state_d.enable = 1'b1;
          state_d.sa_on  = 1'b1;
        end
      end
      ERC_CFG_STANDALONE: begin
        // on/off still free; switch to share silently dropped
        if (sw.ctrl_wr && chip_mode == ERC_MODE_NORMAL) begin
          state_d.enable = sw.ext_reg_enable;
          state_d.sa_on  = sw.ext_reg_enable;
        end
        cfg_attempt = sw.hw_wr && sw.load_share_select;
      end
      ERC_CFG_LOADSHARE: begin
        // share stays set; enable or share clear count as changes
        cfg_attempt = (sw.ctrl_wr && sw.ext_reg_enable)
                      || (sw.hw_wr && !sw.load_share_select);
        state_d.fail = cfg_attempt;
      end
      default: begin
        lock_d.cfg = ERC_CFG_NONE;
      end
    endcase

    // stop-mode share decision taken from keep-on bit
    state_d.ls_stop_mem = state_q.stop_keep;

    // mode table
    mode_ok = 1'b0;
    want_on = 1'b0;
    unique case (chip_mode)
      ERC_MODE_INIT, ERC_MODE_FAIL_SAFE: begin
        want_on = 1'b0;
      end
      ERC_MODE_NORMAL: begin
        want_on = ls_active || (sa_active && state_q.sa_on);
      end
      ERC_MODE_STOP: begin
        want_on = ls_active ? state_q.stop_keep
                            : (sa_active && state_q.sa_on);
      end
      ERC_MODE_SLEEP: begin
        want_on = !ls_active && sa_active && state_q.sa_on;
      end
      ERC_MODE_RESTART: begin
        want_on = ls_active || (sa_active && state_q.sa_on);
      end
      default: begin
        want_on = 1'b0;
      end
    endcase
    mode_ok = want_on && (!ana_s.supply_uv || state_q.uv_keep);

    // stop-mode high-power stage hysteresis
    if (chip_mode != ERC_MODE_STOP || !mode_ok) begin
      state_d.hp_stop = 1'b0;
    end else if (ana_s.base_hi) begin
      state_d.hp_stop = 1'b1;
    end else if (ana_s.base_lo) begin
      state_d.hp_stop = 1'b0;
    end

    state_d.drv.reg_on      = mode_ok;
    state_d.drv.lp_stage_on = mode_ok && chip_mode != ERC_MODE_NORMAL;
    state_d.drv.hp_stage_on = mode_ok && (chip_mode != ERC_MODE_STOP
                                          || state_q.hp_stop);
    state_d.drv.current_limit_on = mode_ok && sa_active;
    state_d.drv.sel_3v3 = sa_active && state_q.vsel;

    // status flags: set wins over clear
    if (sw.oc_clear && !ana_s.shunt_limit) begin
      state_d.oc_flag = 1'b0;
    end
    if (sa_active && state_q.drv.reg_on && ana_s.shunt_limit) begin
      state_d.oc_flag = 1'b1;
    end
    if (sw.uv_clear) begin
      state_d.uv_flag = 1'b0;
    end
    if (sa_active && state_q.drv.reg_on && ana_s.out_uv) begin
      state_d.uv_flag = 1'b1;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!por_n) begin
      lock_q.cfg <= ERC_CFG_NONE;
    end else begin
      lock_q <= lock_d;
    end
  end

  // soft reset leaves lock and share bit, since share follows the lock
  always_ff @(posedge core_clk) begin
    if (!resetn || !por_n) begin
      state_q       <= '0;
      state_q.share <= (lock_q.cfg == ERC_CFG_LOADSHARE) && por_n;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs, all from flops
  assign drv                            = state_q.drv;
  assign cfg_lock                       = lock_q.cfg;
  assign ext_reg_enable                 = state_q.enable;
  assign load_share_select              = state_q.share;
  assign keep_on_in_supply_undervoltage = state_q.uv_keep;
  assign load_share_stop_keep_on        = state_q.stop_keep;
  assign ext_reg_voltage_select         = state_q.vsel;
  assign ext_reg_overcurrent_flag       = state_q.oc_flag;
  assign ext_reg_undervoltage_flag      = state_q.uv_flag;
  assign spi_fail_pulse                 = state_q.fail;

endmodule

// ### erc_pnp_model.sv
`timescale 1ns/10ps
module erc_pnp_model (
  // drive from the block
  input  wire erc_pkg::erc_drv_t drv,
  // bench load conditions
  input  wire logic              vs_low,
  input  wire logic              load_hi,
  input  wire logic              overload,
  input  wire logic              shorted,
  // sensed status
  output erc_pkg::erc_ana_t      ana
);
  import erc_pkg::*;
  // shunt, output and base only react while the pass device conducts
  assign ana.supply_uv   = vs_low;
  assign ana.shunt_limit = drv.reg_on & overload;
  assign ana.out_uv      = drv.reg_on & shorted;
  assign ana.base_hi     = drv.reg_on & load_hi;
  assign ana.base_lo     = ~ana.base_hi;
endmodule

// ### erc_ctrl_props.sv
`timescale 1ns/10ps
module erc_ctrl_props (
  // clock and resets
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic               por_n,
  // watched ports
  input wire erc_pkg::erc_mode_t chip_mode,
  input wire erc_pkg::erc_sw_t   sw,
  input wire erc_pkg::erc_ana_t  ana,
  input wire erc_pkg::erc_drv_t  drv,
  input wire erc_pkg::erc_cfg_t  cfg_lock,
  input wire logic               ext_reg_enable,
  input wire logic               load_share_select,
  input wire logic               keep_on_in_supply_undervoltage,
  input wire logic               load_share_stop_keep_on,
  input wire logic               ext_reg_voltage_select,
  input wire logic               ext_reg_overcurrent_flag,
  input wire logic               ext_reg_undervoltage_flag,
  input wire logic               spi_fail_pulse
);
  import erc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || !por_n);
  a_lock_holds: assert property (disable iff (!por_n)
    cfg_lock != ERC_CFG_NONE |=> $stable(cfg_lock)) else $error("lock moved");
  a_fail_cause: assert property (spi_fail_pulse |->
    $past(cfg_lock) == ERC_CFG_LOADSHARE) else $error("stray fail pulse");
  a_fail_raise: assert property (cfg_lock == ERC_CFG_LOADSHARE &&
    sw.ctrl_wr && sw.ext_reg_enable |=> spi_fail_pulse) else $error("no fail pulse");
  a_sa_lock: assert property (cfg_lock == ERC_CFG_NONE &&
    chip_mode == ERC_MODE_NORMAL && sw.ctrl_wr && sw.ext_reg_enable && !sw.hw_wr
    |=> cfg_lock == ERC_CFG_STANDALONE) else $error("stand-alone not locked");
  a_ls_lock: assert property (cfg_lock == ERC_CFG_NONE &&
    sw.hw_wr && sw.load_share_select |=> cfg_lock == ERC_CFG_LOADSHARE)
    else $error("load share not locked");
  a_ls_no_flags: assert property (cfg_lock == ERC_CFG_LOADSHARE |->
    !ext_reg_overcurrent_flag && !ext_reg_undervoltage_flag && !drv.current_limit_on)
    else $error("flag in load share");
  a_off_modes: assert property (chip_mode inside {ERC_MODE_INIT,
    ERC_MODE_FAIL_SAFE} |=> !drv.reg_on) else $error("on in init or fail-safe");
  a_normal_hp: assert property (drv.reg_on &&
    $past(chip_mode) == ERC_MODE_NORMAL |-> drv.hp_stage_on && !drv.lp_stage_on)
    else $error("stage mix in normal");
  a_ls_stop_off: assert property ((cfg_lock == ERC_CFG_LOADSHARE &&
    chip_mode == ERC_MODE_STOP && !load_share_stop_keep_on) [*2] |-> !drv.reg_on)
    else $error("load share on in stop");
  a_ls_stop_on: assert property ((cfg_lock == ERC_CFG_LOADSHARE &&
    chip_mode == ERC_MODE_STOP && load_share_stop_keep_on && !ana.supply_uv) [*5]
    |-> drv.reg_on) else $error("load share off in stop");
  a_uv_off: assert property ((ana.supply_uv &&
    !keep_on_in_supply_undervoltage) [*4] |-> !drv.reg_on) else $error("on in uv");
endmodule
bind erc_ctrl erc_ctrl_props i_erc_ctrl_props (.*);

// ### erc_ctrl_tb.sv
`timescale 1ns/10ps
module erc_ctrl_tb;
  import erc_pkg::*;
  // ==========
  // signals
  logic      core_clk;
  logic      resetn;
  logic      por_n;
  erc_mode_t chip_mode;
  erc_sw_t   sw;
  erc_ana_t  ana;
  erc_drv_t  drv;
  erc_cfg_t  cfg_lock;
  logic      ls_rb;
  logic      oc_flag;
  logic      uv_flag;
  logic      fail_p;
  logic      vs_low;
  logic      load_hi;
  logic      overload;
  logic      shorted;
  int        fails;
  int        check_count;
  // ==========
  // design and transistor model
  erc_ctrl i_erc_ctrl (.core_clk(core_clk), .resetn(resetn), .por_n(por_n),
    .chip_mode(chip_mode), .sw(sw), .ana(ana), .drv(drv), .cfg_lock(cfg_lock),
    .ext_reg_enable(), .load_share_select(ls_rb),
    .keep_on_in_supply_undervoltage(), .load_share_stop_keep_on(),
    .ext_reg_voltage_select(), .ext_reg_overcurrent_flag(oc_flag),
    .ext_reg_undervoltage_flag(uv_flag), .spi_fail_pulse(fail_p));
  erc_pnp_model i_erc_pnp_model (.drv(drv), .vs_low(vs_low), .load_hi(load_hi),
    .overload(overload), .shorted(shorted), .ana(ana));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // bits: ctrl_wr en hw_wr share uv_keep stop_keep vsel oc_clr uv_clr
  task automatic put(input logic [8:0] v);
    sw = v;
    cyc(1);
    sw = '0;
  endtask
  task automatic close_out;
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50us;
    fails++;
    close_out;
  end
  // ==========
  // tests
  initial begin
    {resetn, por_n, vs_low, load_hi, overload, shorted} = '0;
    fails = 0;
    check_count = 0;
    chip_mode = ERC_MODE_INIT;
    sw = '0;
    cyc(2);
    {resetn, por_n} = 2'b11;
    put(9'h180);
    chk({6'h00, cfg_lock}, 8'h00);
    chip_mode = ERC_MODE_NORMAL;
    put(9'h180);
    chk({6'h00, cfg_lock}, 8'h01);
    cyc(1);
    chk({5'h00, drv[4:2]}, 8'h06);
    put(9'h064);
    chk({5'h00, fail_p, cfg_lock}, 8'h01);
    cyc(1);
    put(9'h044);
    cyc(1);
    chk({7'h00, drv.sel_3v3}, 8'h01);
    put(9'h100);
    cyc(1);
    chk({6'h00, fail_p, drv.reg_on}, 8'h00);
    put(9'h180);
    overload = 1'b1;
    cyc(6);
    put(9'h002);
    chk({7'h00, oc_flag}, 8'h01);
    overload = 1'b0;
    cyc(4);
    put(9'h002);
    chk({7'h00, oc_flag}, 8'h00);
    shorted = 1'b1;
    cyc(6);
    shorted = 1'b0;
    // let the synchronised fault drain, or the set beats the clear
    cyc(3);
    chk({7'h00, uv_flag}, 8'h01);
    put(9'h001);
    chk({7'h00, uv_flag}, 8'h00);
    vs_low = 1'b1;
    cyc(5);
    chk({7'h00, drv.reg_on}, 8'h00);
    vs_low = 1'b0;
    cyc(4);
    chk({7'h00, drv.reg_on}, 8'h01);
    put(9'h054);
    vs_low = 1'b1;
    cyc(5);
    chk({7'h00, drv.reg_on}, 8'h01);
    vs_low = 1'b0;
    chip_mode = ERC_MODE_STOP;
    cyc(4);
    chk({5'h00, drv[4:2]}, 8'h05);
    load_hi = 1'b1;
    cyc(4);
    chk({5'h00, drv[4:2]}, 8'h07);
    load_hi = 1'b0;
    cyc(4);
    chk({5'h00, drv[4:2]}, 8'h05);
    chip_mode = ERC_MODE_FAIL_SAFE;
    cyc(2);
    chk({7'h00, drv.reg_on}, 8'h00);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    chk({6'h00, cfg_lock}, 8'h01);
    por_n = 1'b0;
    cyc(2);
    por_n = 1'b1;
    chk({6'h00, cfg_lock}, 8'h00);
    chip_mode = ERC_MODE_NORMAL;
    put(9'h064);
    chk({5'h00, ls_rb, cfg_lock}, 8'h07);
    cyc(1);
    chk({4'h0, drv[4:2], drv.sel_3v3}, 8'h0c);
    put(9'h180);
    chk({5'h00, fail_p, cfg_lock}, 8'h07);
    cyc(1);
    put(9'h040);
    chk({5'h00, fail_p, ls_rb, drv.reg_on}, 8'h07);
    {overload, shorted} = 2'b11;
    cyc(6);
    {overload, shorted} = 2'b00;
    chk({6'h00, oc_flag, uv_flag}, 8'h00);
    chip_mode = ERC_MODE_STOP;
    cyc(2);
    chk({6'h00, ls_rb, drv.reg_on}, 8'h02);
    chip_mode = ERC_MODE_NORMAL;
    cyc(2);
    chk({7'h00, drv.reg_on}, 8'h01);
    put(9'h068);
    chip_mode = ERC_MODE_STOP;
    cyc(6);
    chk({7'h00, drv.reg_on}, 8'h01);
    chip_mode = ERC_MODE_SLEEP;
    cyc(2);
    chk({7'h00, drv.reg_on}, 8'h00);
    chip_mode = ERC_MODE_RESTART;
    cyc(2);
    chk({7'h00, drv.reg_on}, 8'h01);
    chip_mode = ERC_MODE_FAIL_SAFE;
    cyc(2);
    chk({7'h00, drv.reg_on}, 8'h00);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    chk({5'h00, ls_rb, cfg_lock}, 8'h07);
    close_out;
  end
endmodule
